// file: chip_reset_ctl_if.sv
// Chip reset handshake between the top and the reset sequencer
`timescale 1ns/1ps
`default_nettype none
interface chip_reset_ctl_if;
   logic start;
   logic busy;
   logic done;
   modport ctl (output start, input busy, input done);
   modport seq (input start, output busy, output done);
endinterface
`default_nettype wire

// file: chip_reset_seq.sv
// Sequencer holding the chip core in reset for a fixed number of cycles
`timescale 1ns/1ps
`default_nettype none
module chip_reset_seq #(
   parameter int unsigned HOLD_CYCLES = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   chip_reset_ctl_if.seq rc
);
   localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic busy;
   logic next_busy;
   logic done;
   logic next_done;
   // ==========================================================
   // Next state
   always_comb begin
      next_count = count;
      next_busy = busy;
      next_done = 1'b0;
      if (busy) begin
         if (count == CW'(HOLD_CYCLES - 1)) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_count = '0;
         end else begin
            next_count = count + CW'(1);
         end
      end else if (rc.start) begin
         next_busy = 1'b1;
         next_count = '0;
      end
   end
   // ==========================================================
   // Registers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         count <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         count <= next_count;
         busy <= next_busy;
         done <= next_done;
      end
   end
   assign rc.busy = busy;
   assign rc.done = done;
endmodule
`default_nettype wire

// file: debug_control_status.sv
// Debugger control and status registers with their link command decoder
// Operation
// - While the halt request bit 7 is set the device is in debug state and fetch stops.
// - Clearing the halt request bit lets the processor fetch and execute again.
// - A decoded break opcode 00H with breakpoints enabled sets the halt request bit.
// - Under read protection a write of 0 to the halt request bit is ignored until reset.
// - Breakpoint enable is bit 6, resets to 0, and when 0 the break opcode acts as a no-op.
// - With acknowledge enable bit 5 set a taken breakpoint sends byte FFH to the host, unless a read reply goes out in the same cycle.
// - Writing 1 to bit 0 resets the chip core while the debugger keeps its state.
// - Bit 0 clears itself when that reset ends, and writing 0 to it does nothing.
// - Writes 81H reset and halt, 41H reset and run, and 40H resumes from debug state.
// - Status is read-only, bit 7 shows debug state and bit 6 shows halt mode.
// - Status bit 5 reads 0 under active read protection and 1 otherwise.
// - Command 02H returns the status byte.
// - Command 04H with one data byte writes control and 05H returns control.

`timescale 1ns/1ps
`default_nettype none
`include "debug_control_status_defines.svh"
module debug_control_status #(
   parameter int unsigned RESET_HOLD_CYCLES = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_byte_in,
   output logic tx_valid_out,
   output logic [7:0] tx_byte_out,
   input wire logic opcode_decode_in,
   input wire logic [7:0] opcode_in,
   input wire logic cpu_halt_mode_in,
   input wire logic read_protect_active_in,
   output logic fetch_stall_out,
   output logic chip_reset_out,
   output logic [7:0] debugger_control_reg_out,
   output logic [7:0] debugger_status_reg_out
);

   chip_reset_ctl_if rc ();
   debug_control_status_pkg::cmd_state_t state;
   debug_control_status_pkg::cmd_state_t next_state;
   logic debug_halt_request;
   logic next_debug_halt_request;
   logic breakpoint_enable;
   logic next_breakpoint_enable;
   logic break_ack_enable;
   logic next_break_ack_enable;
   logic reset_bit;
   logic next_reset_bit;
   logic start;
   logic next_start;
   logic tx_valid;
   logic next_tx_valid;
   logic [7:0] tx_byte;
   logic [7:0] next_tx_byte;
   logic chip_reset;
   logic next_chip_reset;
   logic [7:0] ctl_value;
   logic [7:0] stat_value;
   logic break_taken;
   logic [7:0] wr_data;
   logic wr_ctl;
   logic next_dbg_flag;
   logic debug_state_flag;
   logic halt_flag;
   logic read_protect_inactive;
   logic next_halt_flag;
   logic next_read_protect_inactive;

   // ==========================================================
   // Reset sequencer
   chip_reset_seq #(
      .HOLD_CYCLES(RESET_HOLD_CYCLES)
   ) u_seq (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .rc(rc)
   );
   assign rc.start = start;

   // ==========================================================
   // Register views
   always_comb begin
      ctl_value = 8'h00;
      ctl_value[`CTL_HALT_BIT] = debug_halt_request;
      ctl_value[`CTL_BREAKPOINT_ENABLE_BIT] = breakpoint_enable;
      ctl_value[`CTL_ACKEN_BIT] = break_ack_enable;
      ctl_value[`CTL_RESET_BIT] = reset_bit;
      stat_value = 8'h00;
      stat_value[`STAT_DEBUG_BIT] = debug_state_flag;
      stat_value[`STAT_HALT_BIT] = halt_flag;
      stat_value[`STAT_RPI_BIT] = read_protect_inactive;
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_state = state;
      next_tx_valid = 1'b0;
      next_tx_byte = tx_byte;
      wr_ctl = 1'b0;
      wr_data = rx_byte_in;
      unique case (state)
         debug_control_status_pkg::cmd_idle: begin
            if (rx_valid_in) begin
               if (rx_byte_in == `CMD_READ_STATUS) begin
                  next_tx_valid = 1'b1;
                  next_tx_byte = stat_value;
               end else if (rx_byte_in == `CMD_READ_CONTROL) begin
                  next_tx_valid = 1'b1;
                  next_tx_byte = ctl_value;
               end else if (rx_byte_in == `CMD_WRITE_CONTROL) begin
                  next_state = debug_control_status_pkg::cmd_wait_data;
               end
            end
         end
         debug_control_status_pkg::cmd_wait_data: begin
            if (rx_valid_in) begin
               wr_ctl = 1'b1;
               next_state = debug_control_status_pkg::cmd_idle;
            end
         end
      endcase
      // Breakpoint only counts when fetch is running and enabled
      break_taken = opcode_decode_in && (opcode_in == `BREAK_OPCODE) &&
         breakpoint_enable && !debug_halt_request;
      next_debug_halt_request = debug_halt_request;
      next_breakpoint_enable = breakpoint_enable;
      next_break_ack_enable = break_ack_enable;
      next_reset_bit = reset_bit;
      next_start = 1'b0;
      if (wr_ctl) begin
         if (wr_data[`CTL_HALT_BIT] || !read_protect_active_in) begin
            next_debug_halt_request = wr_data[`CTL_HALT_BIT];
         end
         next_breakpoint_enable = wr_data[`CTL_BREAKPOINT_ENABLE_BIT];
         next_break_ack_enable = wr_data[`CTL_ACKEN_BIT];
         if (wr_data[`CTL_RESET_BIT] && !reset_bit) begin
            next_reset_bit = 1'b1;
            next_start = 1'b1;
         end
      end
      // Hardware set wins over a host clear in the same cycle
      if (break_taken) begin
         next_debug_halt_request = 1'b1;
         if (break_ack_enable && !next_tx_valid) begin
            next_tx_valid = 1'b1;
            next_tx_byte = `ACK_BYTE;
         end
      end
      if (rc.done) begin
         next_reset_bit = 1'b0;
      end
      // Start flop bridges the cycle before the sequencer reports busy
      next_chip_reset = next_start || start || rc.busy;
      next_dbg_flag = next_debug_halt_request;
   end

   // ==========================================================
   // Status inputs
   always_comb begin
      // One register stage, so these bits lag their inputs by a cycle
      next_halt_flag = cpu_halt_mode_in;
      next_read_protect_inactive = !read_protect_active_in;
   end

   // ==========================================================
   // Command decoder registers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= debug_control_status_pkg::cmd_idle;
         tx_valid <= 1'b0;
         tx_byte <= `CTL_RESET_VALUE;
      end else begin
         state <= next_state;
         tx_valid <= next_tx_valid;
         tx_byte <= next_tx_byte;
      end
   end

   // ==========================================================
   // Control registers
   // Besides host writes, rc.done clearing reset_bit and start and chip_reset falling when their pulse ends,
   // only rst_n_in clears these, so the debugger survives a chip core reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         debug_halt_request <= 1'b0;
         breakpoint_enable <= 1'b0;
         break_ack_enable <= 1'b0;
         reset_bit <= 1'b0;
         start <= 1'b0;
         chip_reset <= 1'b0;
      end else begin
         debug_halt_request <= next_debug_halt_request;
         breakpoint_enable <= next_breakpoint_enable;
         break_ack_enable <= next_break_ack_enable;
         reset_bit <= next_reset_bit;
         start <= next_start;
         chip_reset <= next_chip_reset;
      end
   end

   // ==========================================================
   // Status registers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         debug_state_flag <= 1'b0;
         halt_flag <= 1'b0;
         read_protect_inactive <= 1'b0;
      end else begin
         debug_state_flag <= next_dbg_flag;
         halt_flag <= next_halt_flag;
         read_protect_inactive <= next_read_protect_inactive;
      end
   end

   // ==========================================================
   // Outputs
   assign tx_valid_out = tx_valid;
   assign tx_byte_out = tx_byte;
   assign fetch_stall_out = debug_halt_request;
   assign chip_reset_out = chip_reset;
   assign debugger_control_reg_out = ctl_value;
   assign debugger_status_reg_out = stat_value;
endmodule
`default_nettype wire

// file: debug_control_status_defines.svh
// Constants of the debugger control and status block
`ifndef DEBUG_CONTROL_STATUS_DEFINES_SVH
`define DEBUG_CONTROL_STATUS_DEFINES_SVH
// ==========================================================
// Link commands
`define CMD_READ_STATUS 8'h02
`define CMD_WRITE_CONTROL 8'h04
`define CMD_READ_CONTROL 8'h05
// ==========================================================
// Control fields
`define CTL_HALT_BIT 7
`define CTL_BREAKPOINT_ENABLE_BIT 6
`define CTL_ACKEN_BIT 5
`define CTL_RESET_BIT 0
`define CTL_RESET_VALUE 8'h00
// ==========================================================
// Status fields
`define STAT_DEBUG_BIT 7
`define STAT_HALT_BIT 6
`define STAT_RPI_BIT 5
// ==========================================================
// Values
`define BREAK_OPCODE 8'h00
`define ACK_BYTE 8'hff
`endif

// file: debug_control_status_monitor.sv
// Concurrent checks on the debugger control and status ports
`timescale 1ns/1ps
`default_nettype none
module debug_control_status_monitor #(
   parameter int unsigned RESET_HOLD_CYCLES = 16
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_byte_in,
   input wire logic tx_valid_out,
   input wire logic [7:0] tx_byte_out,
   input wire logic opcode_decode_in,
   input wire logic [7:0] opcode_in,
   input wire logic cpu_halt_mode_in,
   input wire logic read_protect_active_in,
   input wire logic fetch_stall_out,
   input wire logic chip_reset_out,
   input wire logic [7:0] debugger_control_reg_out,
   input wire logic [7:0] debugger_status_reg_out
);
   wire logic [7:0] c = debugger_control_reg_out;
   wire logic [7:0] s = debugger_status_reg_out;
   wire logic t = opcode_decode_in && opcode_in == 8'h00 && c[6] && !c[7];
   logic wd, next_wd;
   logic [7:0] cnt, next_cnt;
   // Tracks the data byte after a write command, so data is never taken for a command
   always_comb begin
      next_wd = rx_valid_in ? (!wd && rx_byte_in == 8'h04) : wd;
      next_cnt = chip_reset_out ? cnt + 8'h01 : 8'h00;
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wd <= 1'b0;
         cnt <= 8'h00;
      end else begin
         wd <= next_wd;
         cnt <= next_cnt;
      end
   end
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_stall_tracks_halt: assert property (fetch_stall_out == c[7] && s[7] == c[7])
      else $error("stall or debug status off");
   a_reserved_zero: assert property (c[4:1] == 4'h0 && s[4:0] == 5'h00)
      else $error("reserved bits set");
   a_read_reply: assert property (rx_valid_in && !wd && (rx_byte_in == 8'h02 || rx_byte_in == 8'h05)
      |=> tx_valid_out && tx_byte_out == ($past(rx_byte_in) == 8'h05 ? $past(c) : $past(s)))
      else $error("read reply wrong");
   a_break_sets: assert property (t |=> c[7])
      else $error("break not taken");
   a_break_nop: assert property (opcode_decode_in && opcode_in == 8'h00 && !c[6] && !c[7]
      && !rx_valid_in |=> !c[7])
      else $error("break taken while disabled");
   a_ack_sent: assert property (t && c[5] && !rx_valid_in |=> tx_valid_out && tx_byte_out == 8'hff)
      else $error("ack byte missing");
   a_ack_none: assert property (t && !c[5] && !rx_valid_in |=> !tx_valid_out)
      else $error("ack sent while disabled");
   a_protect_hold: assert property (read_protect_active_in && c[7] |=> c[7])
      else $error("halt cleared under protection");
   a_write_takes: assert property (wd && rx_valid_in && !read_protect_active_in && !opcode_decode_in
      |=> c[7:5] == $past(rx_byte_in[7:5]))
      else $error("control write lost");
   a_reset_length: assert property ($fell(chip_reset_out) |-> cnt == 8'(RESET_HOLD_CYCLES + 2))
      else $error("chip reset length wrong");
   a_status_inputs: assert property ($past(rst_n_in) |->
      s[6:5] == {$past(cpu_halt_mode_in), !$past(read_protect_active_in)})
      else $error("status halt or protect bit wrong");
endmodule
`default_nettype wire

// file: debug_control_status_pkg.sv
// Types of the debugger control and status block
package debug_control_status_pkg;
   typedef enum logic [1:0] {
      cmd_idle = 2'b00,
      cmd_wait_data = 2'b01
   } cmd_state_t;
endpackage

// file: debug_host.sv
// Debug host model that sends command and data bytes on the link
`timescale 1ns/1ps
`default_nettype none
module debug_host (
   input wire logic clk_in,
   output logic rx_valid_in,
   output logic [7:0] rx_byte_in
);
   initial begin
      rx_valid_in = 1'b0;
      rx_byte_in = 8'h5a;
   end
   // Inverse after the byte, so a stale value never passes for data
   task automatic send(input logic [7:0] b);
      @(posedge clk_in);
      rx_valid_in <= 1'b1;
      rx_byte_in <= b;
      @(posedge clk_in);
      rx_valid_in <= 1'b0;
      rx_byte_in <= ~b;
   endtask
   task automatic write_ctl(input logic [7:0] v);
      send(8'h04);
      send(v & 8'he1);
   endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench of the debugger control and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int unsigned RESET_HOLD_CYCLES = 2;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic opcode_decode_in = 1'b0;
   logic cpu_halt_mode_in = 1'b0;
   logic read_protect_active_in = 1'b0;
   logic [7:0] opcode_in = 8'h00;
   wire logic rx_valid_in;
   wire logic [7:0] rx_byte_in;
   logic tx_valid_out, fetch_stall_out, chip_reset_out;
   logic [7:0] tx_byte_out, debugger_control_reg_out, debugger_status_reg_out;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h6fc6;
   int mismatches = 0;
   int check_count = 0;
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   debug_host u_host (.clk_in, .rx_valid_in, .rx_byte_in);
   debug_control_status #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) u_dut (.clk_in, .rst_n_in,
      .rx_valid_in, .rx_byte_in, .tx_valid_out, .tx_byte_out, .opcode_decode_in, .opcode_in,
      .cpu_halt_mode_in, .read_protect_active_in, .fetch_stall_out, .chip_reset_out,
      .debugger_control_reg_out, .debugger_status_reg_out);
   // ==========================================================
   // Tasks
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      exp_q.push_back(exp);
      u_host.send(cmd);
      repeat (2) @(negedge clk_in);
   endtask
   task automatic wr(input logic [7:0] v);
      u_host.write_ctl(v);
      repeat (2) @(negedge clk_in);
   endtask
   task automatic break_opcode(input logic [7:0] op);
      @(posedge clk_in);
      opcode_decode_in <= 1'b1;
      opcode_in <= op;
      @(posedge clk_in);
      opcode_decode_in <= 1'b0;
      opcode_in <= ~op;
      repeat (2) @(negedge clk_in);
   endtask
   // Bounded wait, so a stuck core reset ends the run
   task automatic wait_reset_end();
      int n;
      n = 0;
      while (chip_reset_out !== 1'b0 && n < 100) begin
         @(negedge clk_in);
         n++;
      end
      if (chip_reset_out !== 1'b0) begin
         mismatches++;
         stop_test();
      end
   endtask
   always @(negedge clk_in) begin
      if (tx_valid_out === 1'b1) begin
         if (exp_q.size() == 0) begin
            check(8'h01, 8'h00);
         end else begin
            check(tx_byte_out, exp_q.pop_front());
         end
      end
   end
   initial begin
      #200000;
      mismatches++;
      stop_test();
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(negedge clk_in);
      check(debugger_control_reg_out, 8'h00);
      check(debugger_status_reg_out, 8'h20);
      rd(8'h05, 8'h00);
      wr(8'h81);
      check({chip_reset_out, fetch_stall_out, 6'h00}, 8'hc0);
      wait_reset_end();
      @(posedge clk_in);
      cpu_halt_mode_in <= 1'b1;
      rd(8'h05, 8'h80);
      rd(8'h02, 8'he0);
      wr(8'h40);
      check({fetch_stall_out, debugger_control_reg_out[6:0]}, 8'h40);
      wr(8'h41);
      wait_reset_end();
      check(debugger_control_reg_out, 8'h40);
      wr(8'h60);
      seed = lfsr(seed);
      break_opcode({1'b1, seed[6:0]});
      check(debugger_control_reg_out, 8'h60);
      exp_q.push_back(8'hff);
      break_opcode(8'h00);
      check(debugger_control_reg_out, 8'he0);
      wr(8'h40);
      break_opcode(8'h00);
      check(debugger_control_reg_out, 8'hc0);
      wr(8'h00);
      break_opcode(8'h00);
      check(debugger_control_reg_out, 8'h00);
      seed = lfsr(seed);
      u_host.send({1'b1, seed[6:0]});
      wr(8'h40);
      break_opcode(8'h00);
      @(posedge clk_in);
      read_protect_active_in <= 1'b1;
      wr(8'h40);
      check(debugger_control_reg_out, 8'hc0);
      check(debugger_status_reg_out, 8'hc0);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      read_protect_active_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(negedge clk_in);
      check(debugger_control_reg_out, 8'h00);
      check(8'(exp_q.size()), 8'h00);
      stop_test();
   end
endmodule
bind debug_control_status debug_control_status_monitor #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES))
   u_mon (.clk_in, .rst_n_in, .rx_valid_in, .rx_byte_in, .tx_valid_out, .tx_byte_out,
   .opcode_decode_in, .opcode_in, .cpu_halt_mode_in, .read_protect_active_in, .fetch_stall_out,
   .chip_reset_out, .debugger_control_reg_out, .debugger_status_reg_out);
`default_nettype wire
